// ---- hdl/nfcs_pkg.sv ----
package nfcs_pkg;
    // ------------------------------------------------------------------
    // Command codes and unlock addresses.
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_PROG_SETUP = 8'hA0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_IDENT = 8'h90;
    localparam logic [11:0] ADDR_U1_WORD = 12'h555;
    localparam logic [11:0] ADDR_U2_WORD = 12'h2AA;
    localparam logic [11:0] ADDR_U1_BYTE = 12'hAAA;
    localparam logic [11:0] ADDR_U2_BYTE = 12'h555;
    localparam logic [7:0] ID_OFS_PROTECT = 8'h02;
    localparam logic [7:0] ID_OFS_PART = 8'h01;
    localparam logic [7:0] ID_OFS_MAKER = 8'h00;
    // ------------------------------------------------------------------
    // Widths and bus timing counts.
    // ------------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_NS = 8;
    localparam int STROBE_NS = 70;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
    localparam logic [7:0] SEQ_MAX = 8'h06;
    // ------------------------------------------------------------------
    // User operations.
    // ------------------------------------------------------------------
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_PROGRAM = 3'h1;
    localparam logic [2:0] OP_CHIP_ERASE = 3'h2;
    localparam logic [2:0] OP_SECTOR_ERASE = 3'h3;
    localparam logic [2:0] OP_IDENT = 3'h4;
    localparam logic [2:0] OP_RESET = 3'h5;
    localparam logic [2:0] OP_SUSPEND = 3'h6;
    localparam logic [2:0] OP_RESUME = 3'h7;
endpackage

// ---- hdl/nfcs_seq_rom.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Sequence table: one bus cycle of a command, registered output.
// ----------------------------------------------------------------------
module nfcs_seq_rom (
    input wire logic core_clk, // Clock.
    input wire logic clk_en, // Freezes the read register when low.
    input wire logic [2:0] op, // Operation being issued.
    input wire logic [2:0] step, // Bus cycle index within the operation.
    input wire logic byte_mode, // High selects byte-mode unlock addresses.
    output logic [11:0] cyc_addr, // Low address for this cycle.
    output logic [7:0] cyc_data, // Data code for this cycle.
    output logic cyc_user // High when the user address is used; program also takes the user data.
);
    logic [11:0] u1;
    logic [11:0] u2;
    logic [11:0] a_d;
    logic [7:0] d_d;
    logic usr_d;

    // Unlock address pattern depends on the bus width.
    assign u1 = byte_mode ? nfcs_pkg::ADDR_U1_BYTE : nfcs_pkg::ADDR_U1_WORD;
    assign u2 = byte_mode ? nfcs_pkg::ADDR_U2_BYTE : nfcs_pkg::ADDR_U2_WORD;

    // Table of the cycle addresses and data codes.
    always_comb begin
        a_d = u1;
        d_d = nfcs_pkg::CMD_UNLOCK1;
        usr_d = 1'b0;
        unique case (step)
            3'h0: begin
                a_d = u1;
                d_d = nfcs_pkg::CMD_UNLOCK1;
            end
            3'h1: begin
                a_d = u2;
                d_d = nfcs_pkg::CMD_UNLOCK2;
            end
            3'h2: begin
                a_d = u1;
                if (op == nfcs_pkg::OP_PROGRAM) begin
                    d_d = nfcs_pkg::CMD_PROG_SETUP;
                end else if (op == nfcs_pkg::OP_IDENT) begin
                    d_d = nfcs_pkg::CMD_IDENT;
                end else begin
                    d_d = nfcs_pkg::CMD_ERASE_SETUP;
                end
            end
            3'h3: begin
                if (op == nfcs_pkg::OP_PROGRAM) begin
                    usr_d = 1'b1;
                end
            end
            3'h4: begin
                a_d = u2;
                d_d = nfcs_pkg::CMD_UNLOCK2;
            end
            default: begin
                a_d = u1;
                if (op == nfcs_pkg::OP_SECTOR_ERASE) begin
                    d_d = nfcs_pkg::CMD_SECTOR_ERASE;
                    usr_d = 1'b1;
                end else begin
                    d_d = nfcs_pkg::CMD_CHIP_ERASE;
                end
            end
        endcase
    end

    // Read data leave through a register.
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            cyc_addr <= a_d;
            cyc_data <= d_d;
            cyc_user <= usr_d;
        end
    end
endmodule

// ---- hdl/nfcs_host.sv ----
`timescale 1ns/1ps
// Flash rules this block works with
// (RL1) Commands are write cycles; array reads and identification data are read cycles.
// (RL2) Unlock addresses 555H/2AAH in word mode, AAAH/555H in byte mode.
// (RL3) Flash ignores upper address bits 17..11 during command decode.
// (RL4) Flash reads array after power-up and after program or erase completes.
// (RL5) Identification or timed-out status state ends only by reset command.
// (RL6) Erase suspend accepted only while sector erase runs; here OP_SUSPEND is sent only from NFCS_IDLE, after the erase has finished.
// (RL7) Erase resume accepted only while erase-suspended.
// (RL8) Identification: two unlocks, 90H at first unlock, then a read.
// (RL9) Identification read at sector plus 02H gives protect state 01H or 00H.
// (RL10) Reset command accepted at any address.
// (RL11) Reset aborts unfinished erase sequence; ignored once erasing.
// (RL12) Reset aborts unfinished program sequence; ignored once programming.
// (RL13) Reset aborts partial identification sequence, also from suspend.
// (RL14) Reset after exceeded-time flag returns flash to array reads.
// (RL15) Suspended reads inside erasing sectors return status data.
// (RL16) Program is four writes: two unlocks, set-up, address and data.
// (RL17) Flash ignores commands while programming; reset pin terminates it.
// (RL18) Programming only clears bits; zero never returns to one.
// (RL19) Chip erase is six writes ending with the chip-erase code.
// (RL20) Flash preprograms the array itself before erasing.
// (RL21) Flash ignores commands during chip erase; reset pin terminates it.
// (RL22) On completion flash returns to array reads and drops latched addresses.
// (RL23) Wrong address, data or order returns flash to array reads.
// (RL24) Identification offsets 04H, 08H, 0CH, 00H maker; 01H part code.
// (RL25) Codes F0, A0, 80, 10, 30, B0, 30 resume, AA, 55.
// (RL26) Sequence step register advances per write, clears on end or reset; here step_q clears when the next request is taken or on rst_n.
module nfcs_host (
    input wire logic core_clk, // Clock, 125 MHz.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic clk_en, // Freezes all state when low.
    input wire logic byte_mode, // High when the flash is strapped for bytes.
    input wire logic req_valid, // Operation request.
    input wire logic [2:0] req_op, // Operation code.
    input wire logic [17:0] req_addr, // Read, program or sector address.
    input wire logic [15:0] req_data, // Program value.
    output logic req_ready, // High while a request may be taken.
    output logic rsp_valid, // One-cycle pulse with read data or completion.
    output logic [15:0] rsp_data, // Read data or status word.
    output logic busy, // High while flash reports busy.
    output logic time_fault, // Sticky: exceeded-time flag seen.
    output logic [17:0] fl_addr, // Flash address pins.
    output logic [15:0] fl_dq_o, // Flash data out.
    output logic fl_dq_oe, // Data drive enable, high drives.
    input wire logic [15:0] fl_dq_i, // Flash data in.
    output logic fl_ce_n, // Chip enable, active low.
    output logic fl_we_n, // Write enable, active low.
    output logic fl_oe_n, // Output enable, active low.
    output logic fl_reset_n, // Hardware reset pin, active low.
    input wire logic fl_ready_busy_out // Flash ready/busy pin, high ready.
);
    typedef enum logic [4:0] {
        NFCS_IDLE = 5'b00001,
        NFCS_LOAD = 5'b00010,
        NFCS_WR = 5'b00100,
        NFCS_RD = 5'b01000,
        NFCS_WAIT = 5'b10000
    } nfcs_state_t;

    // ------------------------------------------------------------------
    // Pin input synchronisers.
    // ------------------------------------------------------------------
    logic [2:0] rb_q;
    logic [2:0] rb_d;
    logic rdy_s_q;
    logic rdy_s_d;

    // A change counts once the second and third stages agree.
    always_comb begin
        rb_d = {rb_q[1:0], fl_ready_busy_out};
        rdy_s_d = (rb_q[2] == rb_q[1]) ? rb_q[2] : rdy_s_q;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rb_q <= 3'h7;
            rdy_s_q <= 1'b1;
        end else if (clk_en) begin
            rb_q <= rb_d;
            rdy_s_q <= rdy_s_d;
        end
    end

    // ------------------------------------------------------------------
    // Sequence table.
    // ------------------------------------------------------------------
    logic [2:0] step_q;
    logic [2:0] step_d;
    logic [2:0] op_q;
    logic [2:0] op_d;
    logic [11:0] cyc_addr;
    logic [7:0] cyc_data;
    logic cyc_user;

    nfcs_seq_rom u_rom (
        .core_clk(core_clk),
        .clk_en(clk_en),
        .op(op_d),
        .step(step_d),
        .byte_mode(byte_mode),
        .cyc_addr(cyc_addr),
        .cyc_data(cyc_data),
        .cyc_user(cyc_user)
    );

    // Number of bus cycles for each operation.
    function automatic logic [2:0] nfcs_len(input logic [2:0] op);
        unique case (op)
            nfcs_pkg::OP_PROGRAM: nfcs_len = 3'h4; // see (RL16)
            nfcs_pkg::OP_CHIP_ERASE: nfcs_len = 3'h6; // see (RL19)
            nfcs_pkg::OP_SECTOR_ERASE: nfcs_len = 3'h6;
            nfcs_pkg::OP_IDENT: nfcs_len = 3'h4; // see (RL8)
            default: nfcs_len = 3'h1;
        endcase
    endfunction

    // Operations that leave the flash busy in an internal algorithm.
    function automatic logic nfcs_embedded(input logic [2:0] op);
        nfcs_embedded = (op == nfcs_pkg::OP_PROGRAM) || (op == nfcs_pkg::OP_CHIP_ERASE)
            || (op == nfcs_pkg::OP_SECTOR_ERASE) || (op == nfcs_pkg::OP_RESUME);
    endfunction

    // ------------------------------------------------------------------
    // Bus sequencer.
    // ------------------------------------------------------------------
    nfcs_state_t st_q;
    nfcs_state_t st_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [17:0] addr_q;
    logic [17:0] addr_d;
    logic [15:0] data_q;
    logic [15:0] data_d;
    logic [17:0] fa_d;
    logic [15:0] fdo_d;
    logic oe_d;
    logic ce_d;
    logic we_d;
    logic rd_d;
    logic rv_d;
    logic [15:0] rdat_d;
    logic rdy_d;
    logic tf_d;
    logic ident_q;
    logic ident_d;
    logic last;
    logic single;

    assign last = (step_q == nfcs_len(op_q) - 3'h1);
    // Single-cycle operations carry a fixed code at any address.
    assign single = (nfcs_len(op_q) == 3'h1) && (op_q != nfcs_pkg::OP_READ);

    // Next-state logic: each bus cycle is load, strobe, then release.
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        step_d = step_q;
        op_d = op_q;
        addr_d = addr_q;
        data_d = data_q;
        fa_d = fl_addr;
        fdo_d = fl_dq_o;
        oe_d = 1'b0;
        ce_d = 1'b1;
        we_d = 1'b1;
        rd_d = 1'b1;
        rv_d = 1'b0;
        rdat_d = rsp_data;
        rdy_d = 1'b0;
        tf_d = time_fault;
        ident_d = ident_q;
        unique case (st_q)
            NFCS_IDLE: begin
                rdy_d = 1'b1;
                if (req_valid && req_ready) begin
                    op_d = req_op;
                    addr_d = req_addr;
                    data_d = req_data;
                    step_d = 3'h0; // see (RL26)
                    st_d = NFCS_LOAD;
                    rdy_d = 1'b0;
                    if (req_op == nfcs_pkg::OP_RESET) begin
                        tf_d = 1'b0; // see (RL14)
                    end
                end
            end
            NFCS_LOAD: begin
                cnt_d = nfcs_pkg::STROBE_CNT;
                ce_d = 1'b0;
                if (op_q == nfcs_pkg::OP_READ || (op_q == nfcs_pkg::OP_IDENT && last)) begin
                    // Reads: array data, or identification data. see (RL1) (RL24) (RL9)
                    fa_d = addr_q;
                    rd_d = 1'b0;
                    st_d = NFCS_RD;
                end else begin
                    // Upper address bits are don't care; drive zero. see (RL3) (RL2)
                    fa_d = {6'h00, cyc_addr};
                    fdo_d = {8'h00, cyc_data};
                    if (cyc_user) begin
                        fa_d = addr_q;
                        fdo_d = (op_q == nfcs_pkg::OP_PROGRAM) ? data_q : fdo_d;
                    end
                    if (single) begin
                        // Suspend, resume and reset ignore address. see (RL10) (RL25)
                        fa_d = addr_q;
                        unique case (op_q)
                            nfcs_pkg::OP_SUSPEND: fdo_d = {8'h00, nfcs_pkg::CMD_SUSPEND};
                            nfcs_pkg::OP_RESUME: fdo_d = {8'h00, nfcs_pkg::CMD_RESUME};
                            default: fdo_d = {8'h00, nfcs_pkg::CMD_RESET};
                        endcase
                    end
                    oe_d = 1'b1;
                    we_d = 1'b0; // see (RL1)
                    st_d = NFCS_WR;
                end
            end
            NFCS_WR: begin
                ce_d = 1'b0;
                we_d = 1'b0;
                oe_d = 1'b1;
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    // Release strobe; data latches on the rising edge.
                    we_d = 1'b1;
                    ce_d = 1'b1;
                    step_d = step_q + 3'h1;
                    if (!last) begin
                        st_d = NFCS_LOAD;
                    end else if (nfcs_embedded(op_q)) begin
                        cnt_d = nfcs_pkg::STROBE_CNT;
                        st_d = NFCS_WAIT; // see (RL17) (RL21)
                    end else begin
                        if (op_q == nfcs_pkg::OP_RESET) begin
                            ident_d = 1'b0; // see (RL5) (RL13)
                        end
                        rv_d = 1'b1;
                        st_d = NFCS_IDLE;
                    end
                end
            end
            NFCS_RD: begin
                ce_d = 1'b0;
                rd_d = 1'b0;
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    rdat_d = fl_dq_i;
                    rv_d = 1'b1;
                    rd_d = 1'b1;
                    ce_d = 1'b1;
                    if (op_q == nfcs_pkg::OP_IDENT) begin
                        ident_d = 1'b1; // see (RL5)
                    end
                    st_d = NFCS_IDLE;
                end
            end
            NFCS_WAIT: begin
                // Let busy rise before watching for the fall; no commands meanwhile.
                if (cnt_q != 4'h0) begin
                    cnt_d = cnt_q - 4'h1;
                end else if (rdy_s_q) begin
                    rv_d = 1'b1; // see (RL4) (RL22)
                    st_d = NFCS_IDLE;
                end
            end
            default: st_d = NFCS_IDLE;
        endcase
        // Bit 5 of any read word, status or array data, sets the sticky fault flag.
        if (rv_d && rd_d == 1'b1 && st_q == NFCS_RD && fl_dq_i[5]) begin
            tf_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q <= NFCS_IDLE;
            cnt_q <= 4'h0;
            step_q <= 3'h0;
            op_q <= nfcs_pkg::OP_READ;
            addr_q <= 18'h00000;
            data_q <= 16'h0000;
            fl_addr <= 18'h00000;
            fl_dq_o <= 16'h0000;
            fl_dq_oe <= 1'b0;
            fl_ce_n <= 1'b1;
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_reset_n <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 16'h0000;
            req_ready <= 1'b0;
            busy <= 1'b0;
            time_fault <= 1'b0;
            ident_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            step_q <= step_d;
            op_q <= op_d;
            addr_q <= addr_d;
            data_q <= data_d;
            fl_addr <= fa_d;
            fl_dq_o <= fdo_d;
            fl_dq_oe <= oe_d;
            fl_ce_n <= ce_d;
            fl_we_n <= we_d;
            fl_oe_n <= rd_d;
            fl_reset_n <= 1'b1;
            rsp_valid <= rv_d;
            rsp_data <= rdat_d;
            req_ready <= rdy_d;
            busy <= !rdy_s_q;
            time_fault <= tf_d;
            ident_q <= ident_d;
        end
    end
endmodule

// ---- dv/nfcs_host_properties.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Pin-level checks of the flash host.
// ----------------------------------------------------------------------
module nfcs_host_properties (
    input wire logic core_clk, // Clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic clk_en, // Clock enable.
    input wire logic byte_mode, // Byte strap.
    input wire logic req_valid, // Request.
    input wire logic [2:0] req_op, // Operation.
    input wire logic req_ready, // Ready.
    input wire logic rsp_valid, // Response pulse.
    input wire logic busy, // Busy.
    input wire logic time_fault, // Sticky fault.
    input wire logic [17:0] fl_addr, // Flash address.
    input wire logic [15:0] fl_dq_o, // Flash data out.
    input wire logic fl_dq_oe, // Data drive.
    input wire logic fl_ce_n, // Chip enable.
    input wire logic fl_we_n, // Write enable.
    input wire logic fl_oe_n, // Output enable.
    input wire logic fl_reset_n // Flash reset pin.
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // A write strobe holds low for at least 8 cycles, then lets go within the next 3.
    sequence s_we_low;
        (!fl_we_n) [*8];
    endsequence
    sequence s_we_rel;
        ##[0:2] fl_we_n;
    endsequence
    a_we_width: assert property ($fell(fl_we_n) |-> s_we_low ##1 s_we_rel)
        else $error("write strobe width wrong");
    a_strobe_excl: assert property (!(!fl_we_n && !fl_oe_n))
        else $error("read and write strobes overlap");
    a_write_drive: assert property (!fl_we_n |-> fl_dq_oe && !fl_ce_n)
        else $error("write without data drive");
    a_read_float: assert property (!fl_oe_n |-> !fl_dq_oe && !fl_ce_n)
        else $error("read while driving data");
    a_hold_stable: assert property (!fl_we_n && $past(!fl_we_n) |->
        $stable(fl_addr) && $stable(fl_dq_o))
        else $error("address or data moved under strobe");
    a_unlock_addr: assert property (!byte_mode && !fl_we_n && fl_dq_o[7:0] == 8'hAA
        |-> fl_addr[10:0] == 11'h555)
        else $error("first unlock at wrong address");
    a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");
    a_take_busy: assert property (req_valid && req_ready && clk_en |=> !req_ready)
        else $error("ready stayed high after take");
    a_pin_reset: assert property (@(posedge core_clk) disable iff (1'b0)
        !rst_n |=> !fl_reset_n && fl_we_n)
        else $error("flash reset pin not driven in reset");
    a_fault_clear: assert property (req_valid && req_ready && clk_en
        && req_op == nfcs_pkg::OP_RESET |=> !time_fault)
        else $error("fault flag kept after reset op");
    a_quiet_busy: assert property (busy |-> fl_we_n)
        else $error("write issued while flash busy");
endmodule

bind nfcs_host nfcs_host_properties u_props (.core_clk(core_clk), .rst_n(rst_n),
    .clk_en(clk_en), .byte_mode(byte_mode), .req_valid(req_valid), .req_op(req_op),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .busy(busy), .time_fault(time_fault),
    .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_reset_n(fl_reset_n));

// ---- dv/nfcs_flash_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Behavioural flash: small array, command decoder, ready/busy.
// ----------------------------------------------------------------------
module nfcs_flash_model #(
    parameter logic [15:0] MAKER_ID = 16'h00C3, // Arbitrary value.
    parameter logic [15:0] PART_ID = 16'h5A5A, // Arbitrary value.
    parameter int BUSY_NS = 1500
) (
    input wire logic [17:0] addr, // Address pins.
    input wire logic [15:0] dq_in, // Data from the host.
    output logic [15:0] dq_out, // Data to the host.
    input wire logic ce_n, // Chip enable.
    input wire logic we_n, // Write enable.
    input wire logic oe_n, // Output enable.
    input wire logic reset_n, // Hardware reset.
    output logic ready_busy_out // High when ready.
);
    logic [15:0] mem [16];
    logic [15:0] rdval;
    logic [15:0] last;
    logic ident;
    logic fault;
    logic run;
    logic sel = 1'b0;
    int step;
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
        step = 0;
        ident = 0;
        fault = 0;
        run = 0;
        last = 16'h0000;
    end
    assign ready_busy_out = ~run;
    always @(ce_n, we_n) if (!ce_n && !we_n) sel = 1'b1;
    // Read source; a fault keeps status output until a reset command.
    always_comb begin
        if (ident) begin
            case (addr[7:0])
                8'h00, 8'h04, 8'h08, 8'h0C: rdval = MAKER_ID;
                8'h01: rdval = PART_ID;
                8'h02: rdval = {15'h0000, addr[17]};
                default: rdval = 16'h0000;
            endcase
        end else if (fault) rdval = 16'h0020;
        else rdval = mem[addr[3:0]];
    end
    // A released bus shows the inverse of what was last driven, never a hold.
    assign dq_out = (!ce_n && !oe_n) ? rdval : ~last;
    always @(posedge oe_n) last = rdval;
    always @(posedge run) begin
        #(BUSY_NS);
        run = 0;
    end
    always @(negedge reset_n) begin
        step = 0;
        ident = 0;
        run = 0;
    end
    // One step per accepted write; upper address bits play no part.
    always @(posedge we_n) begin : wr
        logic u1;
        logic u2;
        logic [7:0] d;
        u1 = addr[10:0] == 11'h555;
        u2 = addr[10:0] == 11'h2AA;
        d = dq_in[7:0];
        if (sel && reset_n === 1'b1 && !run) begin
            sel = 1'b0;
            if (step == 3) begin
                fault = |(dq_in & ~mem[addr[3:0]]);
                mem[addr[3:0]] &= dq_in;
                step = 0;
                run = 1;
            end else if (d == 8'hF0) begin
                step = 0;
                ident = 0;
                fault = 0;
            end else if (!ident && !fault) begin
                case (step)
                    0: step = (u1 && d == 8'hAA) ? 1 : 0;
                    1: step = (u2 && d == 8'h55) ? 2 : 0;
                    2: begin
                        ident = u1 && d == 8'h90;
                        step = !u1 ? 0 : d == 8'hA0 ? 3 : d == 8'h80 ? 4 : 0;
                    end
                    4: step = (u1 && d == 8'hAA) ? 5 : 0;
                    5: step = (u2 && d == 8'h55) ? 6 : 0;
                    default: begin
                        if (d == 8'h10 || d == 8'h30) begin
                            for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
                            run = 1;
                        end
                        step = 0;
                    end
                endcase
            end
        end
    end
endmodule

// ---- dv/nfcs_host_bench.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Bench: user-side operations against the flash model.
// ----------------------------------------------------------------------
module nfcs_host_bench;
    localparam logic [15:0] MAKER = 16'h00C3; // Arbitrary value.
    localparam logic [15:0] PART = 16'h5A5A; // Arbitrary value.
    logic core_clk, rst_n, req_valid, req_ready, rsp_valid, busy, time_fault;
    logic [2:0] req_op;
    logic [17:0] req_addr, fl_addr;
    logic [15:0] req_data, rsp_data, fl_dq_o, fl_dq_i;
    logic fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_reset_n, fl_rb;
    int miscompares, comparisons;
    logic [17:0] id_a [7] = '{18'h0, 18'h4, 18'h8, 18'hC, 18'h1, 18'h2, 18'h20002};
    logic [15:0] id_e [7] = '{MAKER, MAKER, MAKER, MAKER, PART, 16'h0000, 16'h0001};
    nfcs_host dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .byte_mode(1'b0),
        .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy),
        .time_fault(time_fault), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
        .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
        .fl_reset_n(fl_reset_n), .fl_ready_busy_out(fl_rb));
    nfcs_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) u_flash (.addr(fl_addr),
        .dq_in(fl_dq_o), .dq_out(fl_dq_i), .ce_n(fl_ce_n), .we_n(fl_we_n), .oe_n(fl_oe_n),
        .reset_n(fl_reset_n), .ready_busy_out(fl_rb));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task summarize;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One request, then a bounded wait for its response pulse.
    task do_op(input logic [2:0] o, input logic [17:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge core_clk);
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        req_op = o;
        req_addr = a;
        req_data = d;
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        @(posedge core_clk);
        #1;
        while (rsp_valid !== 1'b1 && n < 4000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= 4000 || req_op !== o) begin
            miscompares++;
            $display("BAD handshake expected %h seen %h", o, req_op);
            summarize();
        end
    endtask
    task rd(input logic [17:0] a, input logic [15:0] exp);
        do_op(nfcs_pkg::OP_READ, a, 16'h0000);
        check("rsp_data", exp, rsp_data);
    endtask
    initial begin
        req_valid = 1'b0;
        req_op = 3'h0;
        req_addr = 18'h00000;
        req_data = 16'h0000;
        miscompares = 0;
        comparisons = 0;
        rst_n = 1'b0;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        rd(18'h00003, 16'hFFFF);
        do_op(nfcs_pkg::OP_PROGRAM, 18'h00003, 16'h1234);
        rd(18'h00003, 16'h1234);
        do_op(nfcs_pkg::OP_PROGRAM, 18'h00003, 16'hFFFF);
        rd(18'h00003, 16'h0020);
        check("time_fault", 16'h0001, {15'h0000, time_fault});
        rd(18'h00007, 16'h0020);
        do_op(nfcs_pkg::OP_RESET, 18'h2A5C1, 16'h0000);
        check("time_fault", 16'h0000, {15'h0000, time_fault});
        rd(18'h00003, 16'h1234);
        for (int i = 0; i < 7; i++) begin
            do_op(nfcs_pkg::OP_IDENT, id_a[i], 16'h0000);
            check("ident", id_e[i], rsp_data);
        end
        do_op(nfcs_pkg::OP_RESET, 18'h00000, 16'h0000);
        rd(18'h00003, 16'h1234);
        do_op(nfcs_pkg::OP_SUSPEND, 18'h00000, 16'h0000);
        do_op(nfcs_pkg::OP_RESUME, 18'h00000, 16'h0000);
        rd(18'h00003, 16'h1234);
        do_op(nfcs_pkg::OP_CHIP_ERASE, 18'h00000, 16'h0000);
        rd(18'h00003, 16'hFFFF);
        do_op(nfcs_pkg::OP_PROGRAM, 18'h00005, 16'h0A5C);
        rd(18'h00005, 16'h0A5C);
        do_op(nfcs_pkg::OP_SECTOR_ERASE, 18'h00005, 16'h0000);
        rd(18'h00005, 16'hFFFF);
        summarize();
    end
endmodule
